// ===== src/bmc_defs.vh
// bmc_defs.vh: constants for the battery mode and charge controller
// assumes a 250 MHz core clock; voltages in millivolts, currents in milliamps
`ifndef BMC_DEFS_VH
`define BMC_DEFS_VH

`define BMC_CLK_MHZ          250
`define BMC_PB_HOLD_MS       40
`define BMC_LED_ON_S         5
// cycle counts derived from the printed times and the clock rate
`define BMC_PB_HOLD_CYC      (`BMC_PB_HOLD_MS * `BMC_CLK_MHZ * 1000)
`define BMC_LED_ON_CYC       (`BMC_LED_ON_S * `BMC_CLK_MHZ * 1000000)

`define BMC_PRE_PCT          15
`define BMC_EOC_PCT          10
`define BMC_RECHG_PCT        5
`define BMC_FIX_HYSTERESIS_SET_PIN_MV      100

`endif

// ===== src/bmc_level_cmp.v
// bmc_level_cmp.v: one battery-level comparator with hysteresis
// assumes threshold and shift words arrive on the core clock
`timescale 1ns/1ns
`default_nettype none
`include "bmc_defs.vh"

module bmc_level_cmp #(
  parameter W = 16
) (
  input  wire         i_mclk,
  input  wire         i_srst,
  input  wire [W-1:0] i_vbat,
  input  wire [W-1:0] i_thr,
  input  wire [W-1:0] i_win,
  input  wire         i_rising,
  input  wire         i_comp_up,
  input  wire         i_comp_dn,
  input  wire [W-1:0] i_comp,
  output reg          o_lit_r
);

  localparam [W+1:0] FIX = `BMC_FIX_HYSTERESIS_SET_PIN_MV;

  reg [W+1:0] base;
  reg [W+1:0] on_lvl;
  reg [W+1:0] off_lvl;

  // rising uses raised set, falling uses lowered set; compensation shifts both
  always @*
  begin
    base = {2'b00, i_thr};
    if (i_rising)
      base = base + {2'b00, i_win}; // [RL14]
    if (i_comp_up)
      base = base + {2'b00, i_comp}; // [RL16]
    else if (i_comp_dn && base > {2'b00, i_comp})
      base = base - {2'b00, i_comp}; // [RL16]
    on_lvl  = base + FIX; // [RL15]
    off_lvl = base;
  end

  // fixed band stops chatter around the trip point
  always @(posedge i_mclk)
  begin
    if (i_srst)
      o_lit_r <= 1'b0;
    else if ({2'b00, i_vbat} >= on_lvl)
      o_lit_r <= 1'b1; // [RL15]
    else if ({2'b00, i_vbat} < off_lvl)
      o_lit_r <= 1'b0;
  end

endmodule
`default_nettype wire

// ===== src/bmc_ctrl.v
// bmc_ctrl.v: mode select, charge sequencer, balance, button, level indicators
// assumes analog measurements arrive as sampled words on the core clock;
// the button pin and supply-valid / battery-present flags are asynchronous.
//
// How it works
// [RL1] default and reset mode is high impedance when nothing else is selected
// [RL2] high impedance keeps all switches off; only button watching stays alive
// [RL3] valid input supply selects charge mode with boost converter
// [RL4] charge steps trickle, precondition, fast, top-off, end of charge
// [RL5] precondition asks for 15 percent of fast-charge current
// [RL6] precondition moves to fast once battery reaches precondition threshold
// [RL7] fast charge runs constant current until termination voltage, then top-off
// [RL8] top-off ends when current below 10 percent of fast current
// [RL9] end of charge restarts when both cells fall 5 percent below
// [RL10] battery removed while charging: boost regulates at regulation voltage
// [RL11] bleed switches only enabled in fast charge or top-off
// [RL12] button watched in high impedance and discharge modes
// [RL13] button held over 40 ms: indicators on 5 s, discharge enabled; code acts on a hold only in high impedance, a hold in discharge does nothing
// [RL14] rising battery uses raised thresholds, falling uses lowered ones; code selects the lowered set for a rise outside charge mode
// [RL15] every level comparator has fixed 100 mV hysteresis
// [RL16] thresholds shift by current times impedance; none when not configured
// [RL17] valid supply wins over button request
`timescale 1ns/1ns
`default_nettype none
`include "bmc_defs.vh"

module bmc_ctrl #(
  parameter W        = 16,
  parameter NLED     = 4,
  parameter PB_CYC   = `BMC_PB_HOLD_CYC,
  parameter LED_CYC  = `BMC_LED_ON_CYC
) (
  input  wire            i_mclk,
  input  wire            i_srst,
  input  wire            i_vin_valid,
  input  wire            i_bat_present,
  input  wire            i_push_button_input,
  input  wire            i_dis_off,
  input  wire [W-1:0]    i_vbat,
  input  wire [W-1:0]    i_vcell1,
  input  wire [W-1:0]    i_vcell2,
  input  wire [W-1:0]    i_ibat,
  input  wire [W-1:0]    i_ifast,
  input  wire [W-1:0]    i_vtrickle,
  input  wire [W-1:0]    i_vprecond,
  input  wire [W-1:0]    i_vterm,
  input  wire [W-1:0]    i_veoc_cell,
  input  wire [W*NLED-1:0] i_led_thr,
  input  wire [W*NLED-1:0] i_hysteresis_set_pin_win,
  input  wire            i_comp_en,
  input  wire [W-1:0]    i_comp_mv,
  output reg             o_boost_en_r,
  output reg             o_buck_en_r,
  output reg             o_high_impedance_mode_r,
  output reg             o_cc_mode_r,
  output reg             o_cv_mode_r,
  output reg             o_vreg_mode_r,
  output reg  [W-1:0]    o_iset_r,
  output reg             o_bleed1_r,
  output reg             o_bleed2_r,
  output reg  [5:0]      o_chg_state_r,
  output reg  [NLED-1:0] o_led_r
);

  // charge states, one-hot
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_TRK  = 6'h02;
  localparam [5:0] S_PRE  = 6'h04;
  localparam [5:0] S_FAST = 6'h08;
  localparam [5:0] S_TOP  = 6'h10;
  localparam [5:0] S_EOC  = 6'h20;

  // operating modes, one-hot
  localparam [2:0] M_HZ  = 3'h1;
  localparam [2:0] M_CHG = 3'h2;
  localparam [2:0] M_DIS = 3'h4;

  localparam [31:0] PB_MAX  = PB_CYC;
  localparam [31:0] LED_MAX = LED_CYC;

  // two-flop synchronisers for asynchronous levels
  reg [2:0] meta_r;
  reg [2:0] sync_r;
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end
    else
    begin
      meta_r <= {i_push_button_input, i_bat_present, i_vin_valid};
      sync_r <= meta_r;
    end
  end
  wire vin_ok  = sync_r[0];
  wire bat_ok  = sync_r[1];
  wire pb_down = sync_r[2];

  reg [2:0]  mode_r;
  reg [2:0]  mode_nxt;
  reg [5:0]  st_nxt;
  reg [31:0] pb_cnt_r;
  reg        pb_hit_r;
  reg [31:0] led_cnt_r;
  reg        show_r;
  reg [W-1:0] vbat_prev_r;
  reg        rising_r;

  // button watched only when not charging; one hit per press
  wire pb_watch = (mode_r == M_HZ) || (mode_r == M_DIS); // [RL12]
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      pb_cnt_r <= 32'h0;
      pb_hit_r <= 1'b0;
    end
    else if (!pb_watch || !pb_down)
    begin
      pb_cnt_r <= 32'h0;
      pb_hit_r <= 1'b0;
    end
    else if (pb_cnt_r < PB_MAX)
    begin
      pb_cnt_r <= pb_cnt_r + 32'h1;
      pb_hit_r <= 1'b0;
    end
    else
    begin
      pb_cnt_r <= pb_cnt_r + 32'h1; // strictly longer than the hold time
      pb_hit_r <= (pb_cnt_r == PB_MAX); // [RL13]
    end
  end

  wire pb_wake = pb_hit_r && (mode_r == M_HZ);

  // mode select: supply beats button, otherwise rest in high impedance
  always @*
  begin
    mode_nxt = mode_r;
    case (mode_r)
      M_HZ:
        if (vin_ok)
          mode_nxt = M_CHG; // [RL3] [RL17]
        else if (pb_wake)
          mode_nxt = M_DIS; // [RL13]
      M_CHG:
        if (!vin_ok)
          mode_nxt = M_HZ; // [RL1]
      M_DIS:
        if (vin_ok)
          mode_nxt = M_CHG; // [RL17]
        else if (i_dis_off)
          mode_nxt = M_HZ; // [RL1]
      default:
        mode_nxt = M_HZ;
    endcase
  end

  // percentages of the programmed fast current and end-of-charge cell voltage, widened to avoid overflow
  localparam [W+7:0] PCT_PRE   = `BMC_PRE_PCT;
  localparam [W+7:0] PCT_EOC   = `BMC_EOC_PCT;
  localparam [W+7:0] PCT_RECHG = 100 - `BMC_RECHG_PCT;
  localparam [W+7:0] PCT_FULL  = 100;
  wire [W+7:0] pre_i   = ({8'h00, i_ifast} * PCT_PRE) / PCT_FULL;
  wire [W+7:0] eoc_i   = ({8'h00, i_ifast} * PCT_EOC) / PCT_FULL;
  wire [W+7:0] rechg_v = ({8'h00, i_veoc_cell} * PCT_RECHG) / PCT_FULL;
  wire both_low = ({8'h00, i_vcell1} < rechg_v) && ({8'h00, i_vcell2} < rechg_v);

  // charge sequencer, runs only in charge mode
  always @*
  begin
    st_nxt = o_chg_state_r;
    if (mode_r != M_CHG)
      st_nxt = S_IDLE;
    else
      case (o_chg_state_r)
        S_IDLE: st_nxt = S_TRK;
        S_TRK:
          if (i_vbat >= i_vtrickle)
            st_nxt = S_PRE; // [RL4]
        S_PRE:
          if (i_vbat >= i_vprecond)
            st_nxt = S_FAST; // [RL6]
        S_FAST:
          if (i_vbat >= i_vterm)
            st_nxt = S_TOP; // [RL7]
        S_TOP:
          if ({8'h00, i_ibat} < eoc_i)
            st_nxt = S_EOC; // [RL8]
        S_EOC:
          if (both_low)
            st_nxt = S_TRK; // [RL9]
        default: st_nxt = S_IDLE;
      endcase
  end

  // state and mode registers
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      mode_r        <= M_HZ; // [RL1]
      o_chg_state_r <= S_IDLE;
    end
    else
    begin
      mode_r        <= mode_nxt;
      o_chg_state_r <= st_nxt;
    end
  end

  // converter and switch drive; all off in high impedance
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_boost_en_r            <= 1'b0;
      o_buck_en_r             <= 1'b0;
      o_high_impedance_mode_r <= 1'b1;
      o_cc_mode_r             <= 1'b0;
      o_cv_mode_r             <= 1'b0;
      o_vreg_mode_r           <= 1'b0;
      o_iset_r                <= {W{1'b0}};
      o_bleed1_r              <= 1'b0;
      o_bleed2_r              <= 1'b0;
    end
    else
    begin
      o_high_impedance_mode_r <= (mode_r == M_HZ); // [RL2]
      o_boost_en_r  <= (mode_r == M_CHG); // [RL3]
      o_buck_en_r   <= (mode_r == M_DIS);
      // no battery: regulate output voltage instead of charging
      o_vreg_mode_r <= (mode_r == M_CHG) && !bat_ok; // [RL10]
      o_cc_mode_r   <= (mode_r == M_CHG) && bat_ok &&
                       (o_chg_state_r == S_FAST || o_chg_state_r == S_PRE); // [RL7]
      o_cv_mode_r   <= (mode_r == M_CHG) && bat_ok && (o_chg_state_r == S_TOP);
      if (mode_r != M_CHG || !bat_ok)
        o_iset_r <= {W{1'b0}}; // [RL2]
      else if (o_chg_state_r == S_PRE)
        o_iset_r <= pre_i[W-1:0]; // [RL5]
      else if (o_chg_state_r == S_FAST || o_chg_state_r == S_TOP)
        o_iset_r <= i_ifast;
      else
        o_iset_r <= {W{1'b0}};
      // bleed the higher cell, only in fast or top-off
      o_bleed1_r <= (mode_r == M_CHG) && (o_chg_state_r == S_FAST || o_chg_state_r == S_TOP)
                    && (i_vcell1 > i_vcell2); // [RL11]
      o_bleed2_r <= (mode_r == M_CHG) && (o_chg_state_r == S_FAST || o_chg_state_r == S_TOP)
                    && (i_vcell2 > i_vcell1); // [RL11]
    end
  end

  // indicator window after a button wake; long count kept as parameter
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      led_cnt_r <= 32'h0;
      show_r    <= 1'b0;
    end
    else if (pb_wake)
    begin
      led_cnt_r <= LED_MAX; // [RL13]
      show_r    <= 1'b1;
    end
    else if (led_cnt_r != 32'h0)
      led_cnt_r <= led_cnt_r - 32'h1;
    else
      show_r <= 1'b0;
  end

  // direction of battery voltage for threshold set choice
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      vbat_prev_r <= {W{1'b0}};
      rising_r    <= 1'b0;
    end
    else
    begin
      vbat_prev_r <= i_vbat;
      if (i_vbat > vbat_prev_r)
        rising_r <= (mode_r == M_CHG); // [RL14]
      else if (i_vbat < vbat_prev_r)
        rising_r <= 1'b0;
    end
  end

  // one comparator per level; compensation ignored when not configured
  wire [NLED-1:0] lit;
  wire comp_up = i_comp_en && (mode_r == M_CHG); // [RL16]
  wire comp_dn = i_comp_en && (mode_r == M_DIS); // [RL16]
  genvar g;
  generate
    for (g = 0; g < NLED; g = g + 1)
    begin : g_lvl
      bmc_level_cmp #(.W(W)) u_cmp (
        .i_mclk    (i_mclk),
        .i_srst    (i_srst),
        .i_vbat    (i_vbat),
        .i_thr     (i_led_thr[g*W +: W]),
        .i_win     (i_hysteresis_set_pin_win[g*W +: W]),
        .i_rising  (rising_r),
        .i_comp_up (comp_up),
        .i_comp_dn (comp_dn),
        .i_comp    (i_comp_mv),
        .o_lit_r   (lit[g])
      );
    end
  endgenerate

  // indicators show in charge, or during the button window
  always @(posedge i_mclk)
  begin
    if (i_srst)
      o_led_r <= {NLED{1'b0}};
    else if (mode_r == M_CHG || show_r)
      o_led_r <= lit;
    else
      o_led_r <= {NLED{1'b0}};
  end

endmodule
`default_nettype wire

// ===== tb/bmc_ctrl_props.sv
// bmc_ctrl_props.sv: port-level checks for the mode and charge controller
// assumes one clock domain and the synchronous reset of bmc_ctrl
`timescale 1ns/1ns
`default_nettype none
module bmc_ctrl_props #(
  parameter W = 16
) (
  input wire logic         i_mclk,
  input wire logic         i_srst,
  input wire logic         i_vin_valid,
  input wire logic [W-1:0] i_vbat,
  input wire logic [W-1:0] i_ibat,
  input wire logic [W-1:0] i_ifast,
  input wire logic [W-1:0] i_vprecond,
  input wire logic [W-1:0] i_vterm,
  input wire logic         o_boost_en_r,
  input wire logic         o_buck_en_r,
  input wire logic         o_high_impedance_mode_r,
  input wire logic         o_cv_mode_r,
  input wire logic [W-1:0] o_iset_r,
  input wire logic         o_bleed1_r,
  input wire logic         o_bleed2_r,
  input wire logic [5:0]   o_chg_state_r
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  // state codes are one-hot, so a legal step is a left shift, a wrap or a return to idle
  a_reset_idle: assert property ($past(i_srst) |-> o_high_impedance_mode_r
    && o_chg_state_r == 6'h01) else $error("not idle after reset");
  a_hz_quiet: assert property (o_high_impedance_mode_r |-> !o_boost_en_r
    && !o_buck_en_r && !o_bleed1_r && !o_bleed2_r) else $error("switch on in idle");
  a_supply_boost: assert property ($rose(i_vin_valid) ##1 i_vin_valid[*5]
    |-> o_boost_en_r) else $error("no boost after supply");
  a_state_step: assert property ($changed(o_chg_state_r) |-> o_chg_state_r == 6'h01
    || o_chg_state_r == {$past(o_chg_state_r[4:0]), 1'b0}
    || ($past(o_chg_state_r) == 6'h20 && o_chg_state_r == 6'h02))
    else $error("illegal charge step");
  a_pre_current: assert property ((o_chg_state_r == 6'h04)[*3] |->
    32'(o_iset_r) == 32'(i_ifast) * 15 / 100) else $error("precondition current");
  a_pre_exit: assert property ($past(o_chg_state_r) == 6'h04 && o_chg_state_r == 6'h08
    |-> $past(i_vbat) >= $past(i_vprecond)) else $error("early fast charge");
  a_fast_exit: assert property ($past(o_chg_state_r) == 6'h08 && o_chg_state_r == 6'h10
    |-> $past(i_vbat) >= $past(i_vterm)) else $error("early top-off");
  a_top_cv: assert property ((o_chg_state_r == 6'h10)[*2] |-> o_cv_mode_r)
    else $error("top-off not constant voltage");
  a_top_exit: assert property ($past(o_chg_state_r) == 6'h10 && o_chg_state_r == 6'h20
    |-> 32'($past(i_ibat)) * 10 < 32'(i_ifast)) else $error("early end of charge");
  a_bleed_window: assert property (o_bleed1_r || o_bleed2_r |->
    ((o_chg_state_r | $past(o_chg_state_r)) & 6'h18) != 6'h00) else $error("bleed outside");
  a_supply_first: assert property (o_boost_en_r |-> !o_buck_en_r)
    else $error("boost and buck together");

  c_eoc: cover property (o_chg_state_r == 6'h20);
  c_buck: cover property ($rose(o_buck_en_r));
  c_bleed: cover property ($rose(o_bleed1_r) || $rose(o_bleed2_r));
endmodule

bind bmc_ctrl bmc_ctrl_props #(.W(W)) i_bmc_ctrl_props (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_vin_valid(i_vin_valid), .i_vbat(i_vbat),
  .i_ibat(i_ibat), .i_ifast(i_ifast), .i_vprecond(i_vprecond), .i_vterm(i_vterm),
  .o_boost_en_r(o_boost_en_r), .o_buck_en_r(o_buck_en_r), .o_cv_mode_r(o_cv_mode_r),
  .o_high_impedance_mode_r(o_high_impedance_mode_r), .o_iset_r(o_iset_r),
  .o_bleed1_r(o_bleed1_r), .o_bleed2_r(o_bleed2_r), .o_chg_state_r(o_chg_state_r));
`default_nettype wire

// ===== tb/bmc_pack_model.sv
// bmc_pack_model.sv: two-cell pack, supply and button seen from the controller
// assumes the bench commands plug, press, removal and load drain
`timescale 1ns/1ns
`default_nettype none
module bmc_pack_model #(
  parameter logic [15:0] V0 = 16'h1388
) (
  input  wire logic        i_mclk,
  input  wire logic        i_plug,
  input  wire logic        i_press,
  input  wire logic        i_remove,
  input  wire logic        i_drain,
  input  wire logic        i_boost,
  input  wire logic        i_cv,
  input  wire logic [15:0] i_iset,
  output wire logic        o_vin_valid,
  output wire logic        o_bat_present,
  output wire logic        o_pb,
  output var  logic [15:0] o_vbat,
  output wire logic [15:0] o_vc1,
  output wire logic [15:0] o_vc2,
  output var  logic [15:0] o_ibat
);
  // pins follow the bench commands directly
  assign o_vin_valid   = i_plug;
  assign o_bat_present = !i_remove;
  assign o_pb          = i_press;
  // lower cell slightly weaker so the cells are never exactly equal
  assign o_vc1 = (o_vbat >> 1) - 16'h0002;
  assign o_vc2 = o_vbat - o_vc1;
  initial o_vbat = V0;
  initial o_ibat = 16'h0000;
  // voltage rises whenever boost is on outside constant voltage and drain is off, even at zero current; current tapers under constant voltage
  always @(posedge i_mclk)
  begin
    if (i_drain)
      o_vbat <= o_vbat - 16'h0020;
    else if (i_boost && !i_cv)
      o_vbat <= o_vbat + 16'h0010;
    if (!i_boost || i_iset == 16'h0000)
      o_ibat <= 16'h0000;
    else if (!i_cv)
      o_ibat <= i_iset;
    else if (o_ibat > 16'h0008)
      o_ibat <= o_ibat - 16'h0008;
  end
endmodule
`default_nettype wire

// ===== tb/bmc_ctrl_bench.sv
// bmc_ctrl_bench.sv: self-checking bench for the mode and charge controller
// assumes short button and indicator counts; inputs change on falling edges
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: got %h, expected %h", $time, (a), (b)); end end
module bmc_ctrl_bench;
  logic        mclk, srst, plug, press, remove, drain, dis_off, comp_en;
  logic [15:0] ifast, vtrk, vpre, vterm, veoc, comp_mv;
  logic [63:0] led_thr, hysteresis_set_pin_win;
  wire logic        vin_valid, bat_present, pb, boost, buck, hz, cc, cv, vreg, bl1, bl2;
  wire logic [15:0] vbat, vc1, vc2, ibat, iset;
  wire logic [5:0]  st;
  wire logic [3:0]  led;
  int          fails, cmp_count;

  bmc_ctrl #(.PB_CYC(8), .LED_CYC(20)) i_bmc_ctrl (
    .i_mclk(mclk), .i_srst(srst), .i_vin_valid(vin_valid), .i_bat_present(bat_present),
    .i_push_button_input(pb), .i_dis_off(dis_off), .i_vbat(vbat), .i_vcell1(vc1),
    .i_vcell2(vc2), .i_ibat(ibat), .i_ifast(ifast), .i_vtrickle(vtrk), .i_vprecond(vpre),
    .i_vterm(vterm), .i_veoc_cell(veoc), .i_led_thr(led_thr), .i_hysteresis_set_pin_win(hysteresis_set_pin_win),
    .i_comp_en(comp_en), .i_comp_mv(comp_mv), .o_boost_en_r(boost), .o_buck_en_r(buck),
    .o_high_impedance_mode_r(hz), .o_cc_mode_r(cc), .o_cv_mode_r(cv),
    .o_vreg_mode_r(vreg), .o_iset_r(iset), .o_bleed1_r(bl1), .o_bleed2_r(bl2),
    .o_chg_state_r(st), .o_led_r(led));
  bmc_pack_model i_bmc_pack_model (
    .i_mclk(mclk), .i_plug(plug), .i_press(press), .i_remove(remove), .i_drain(drain),
    .i_boost(boost), .i_cv(cv), .i_iset(iset), .o_vin_valid(vin_valid),
    .o_bat_present(bat_present), .o_pb(pb), .o_vbat(vbat), .o_vc1(vc1), .o_vc2(vc2),
    .o_ibat(ibat));

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // bounded wait for a charge state; running out ends the run
  task automatic wait_st(input logic [5:0] s);
    int n;
    n = 0;
    while (st !== s && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 3000)
    begin
      fails++;
      final_report;
    end
  endtask

  task automatic t_reset;
    `CHK({hz, st}, 7'h41)
    `CHK({boost, buck, bl1, bl2}, 4'h0)
    $display("t_reset done");
  endtask

  // short hold at the count boundary, then a real hold, then load drop-out
  task automatic t_button;
    press = 1;
    ticks(8);
    press = 0;
    ticks(8);
    `CHK(buck, 1'b0)
    press = 1;
    ticks(14);
    press = 0;
    ticks(2);
    `CHK({buck, led}, 5'h1f)
    ticks(30);
    `CHK(led, 4'h0)
    dis_off = 1;
    ticks(2);
    dis_off = 0;
    ticks(3);
    `CHK({hz, buck}, 2'b10)
    press = 1;
    ticks(14);
    press = 0;
    plug = 1;
    ticks(6);
    `CHK({boost, buck}, 2'b10)
    $display("t_button done");
  endtask

  task automatic t_charge;
    wait_st(6'h02);
    `CHK(boost, 1'b1)
    wait_st(6'h04);
    ticks(2);
    `CHK(iset, 16'h0096)
    wait_st(6'h08);
    `CHK(vbat >= vpre, 1'b1)
    press = 1;
    ticks(14);
    press = 0;
    `CHK(buck, 1'b0)
    `CHK({cc, bl1, bl2}, 3'b101)
    wait_st(6'h10);
    ticks(2);
    `CHK({cv, vbat >= vterm}, 2'b11)
    wait_st(6'h20);
    `CHK(st, 6'h20)
    drain = 1;
    wait_st(6'h02);
    drain = 0;
    `CHK(32'(vc2) * 20 < 32'(veoc) * 19, 1'b1)
    remove = 1;
    ticks(6);
    `CHK(vreg, 1'b1)
    remove = 0;
    plug = 0;
    ticks(6);
    `CHK({hz, boost}, 2'b10)
    $display("t_charge done");
  endtask

  initial
  begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end

  initial
  begin
    {plug, press, remove, drain, dis_off, comp_en} = 6'h00;
    srst = 1;
    fails = 0;
    cmp_count = 0;
    ifast = 16'h03e8;
    vtrk = 16'h15e0;
    vpre = 16'h1770;
    vterm = 16'h20d0;
    veoc = 16'h1068;
    comp_mv = 16'h0000;
    led_thr = {16'h1194, 16'h0fa0, 16'h0dac, 16'h0bb8};
    hysteresis_set_pin_win = 64'h0;
    ticks(16);
    srst = 0;
    ticks(2);
    t_reset;
    t_button;
    t_charge;
    final_report;
  end
endmodule
`default_nettype wire
